// file: logic/scp_clock_source.sv
// System clock source selection and output prescaler.
// Assumes clock pins are slow against i_clk_sys and that configuration
// inputs come from logic on the same clock.
// A new source that stops leaves a pending switch waiting in the arm state; an old one stopped high leaves it in drain.
`timescale 1ns/1ps

// Summary of operation
// - Select 11 runs the system clock straight from the direct clock input.
// - Direct drive keeps the input's high and low phases, no reshaping.
// - Select 10 with bypass 1 divides crystal or internal clock by field plus one.
// - Division factor reaches 1024, giving oscillator frequency over 1024.
// - Factor 1 passes the oscillator clock with its own duty cycle.
// - Crystal bypass with factor 1 behaves like direct drive.
// - Select 00 takes the system clock from the wakeup clock source.
module scp_clock_source (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  input  wire logic        i_direct_clock_input,
  input  wire logic        i_crystal_input,
  input  wire logic        i_internal_clock,
  input  wire logic        i_wakeup_clock,
  input  wire logic [1:0]  i_clock_source_select,
  input  wire logic        i_oscillator_bypass_select,
  input  wire logic        i_oscillator_from_internal,
  input  wire logic [9:0]  i_prescaler_divide_field,
  output logic             o_sys_clk,
  output logic             o_switch_busy,
  output logic [1:0]       o_active_select
);

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  logic [scp_pkg::NUM_SRC-1:0] pin_vec;
  logic [scp_pkg::NUM_SRC-1:0] lvl_q;
  logic [scp_pkg::NUM_SRC-1:0] lvl_prev_q;

  assign pin_vec = {i_wakeup_clock, i_internal_clock, i_crystal_input, i_direct_clock_input};

  // A level is accepted only once the second and third stages agree
  for (genvar g = 0; g < scp_pkg::NUM_SRC; g++) begin : g_sync
    logic [scp_pkg::SYNC_STAGES-1:0] sync_q;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
        sync_q        <= '0;
        lvl_q[g]      <= 1'b0;
        lvl_prev_q[g] <= 1'b0;
      end else begin
        sync_q        <= {sync_q[1:0], pin_vec[g]};
        lvl_prev_q[g] <= lvl_q[g];
        if (sync_q[1] == sync_q[2]) begin
          lvl_q[g] <= sync_q[2];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Requested configuration
  // ----------------------------------------------------------------
  logic [1:0]               req_src;
  logic [scp_pkg::DIV_W-1:0] req_div;
  logic                     req_ok;

  always_comb begin
    req_src = scp_pkg::SRC_WAKEUP;
    req_div = '0;
    req_ok  = 1'b1;
    case (i_clock_source_select)
      scp_pkg::SEL_DIRECT: begin
        req_src = scp_pkg::SRC_DIRECT;
      end
      scp_pkg::SEL_PRESCALE: begin
        // Multiplier path is not part of this block; it idles low
        req_ok  = i_oscillator_bypass_select;
        req_src = i_oscillator_from_internal ? scp_pkg::SRC_INTERN
                                             : scp_pkg::SRC_CRYSTAL;
        req_div = i_prescaler_divide_field;
      end
      scp_pkg::SEL_WAKEUP: begin
        req_src = scp_pkg::SRC_WAKEUP;
      end
      default: begin
        req_ok = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Active configuration and switch sequencer
  // ----------------------------------------------------------------
  scp_pkg::scp_state_e       state_q;
  logic [1:0]                act_sel_q;
  logic [1:0]                act_src_q;
  logic [scp_pkg::DIV_W-1:0] act_div_q;
  logic                      act_ok_q;
  logic [scp_pkg::DIV_W-1:0] half_cnt_q;
  logic                      out_q;
  logic                      cfg_change;
  logic                      cfg_load;
  logic                      src_lvl;
  logic                      src_edge;
  logic                      src_rise;
  logic                      half_done;

  assign cfg_change = (i_clock_source_select != act_sel_q) || (req_src != act_src_q) ||
                      (req_div != act_div_q) || (req_ok != act_ok_q);
  // The new setting is taken only while the output rests low
  assign cfg_load   = (state_q == scp_pkg::ST_DRAIN) && !out_q;
  assign src_lvl    = lvl_q[act_src_q];
  assign src_edge   = lvl_q[act_src_q] ^ lvl_prev_q[act_src_q];
  assign src_rise   = src_edge && src_lvl;
  assign half_done  = (half_cnt_q == act_div_q);

  // Switching only while the output is low, and restarting on a rising
  // edge of the new source, stretches the low phase instead of cutting it
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= scp_pkg::ST_RUN;
    end else begin
      case (state_q)
        scp_pkg::ST_RUN: begin
          if (cfg_change) begin
            state_q <= scp_pkg::ST_DRAIN;
          end
        end
        scp_pkg::ST_DRAIN: begin
          if (cfg_load) begin
            state_q <= scp_pkg::ST_ARM;
          end
        end
        scp_pkg::ST_ARM: begin
          if (src_rise || !act_ok_q) begin
            state_q <= scp_pkg::ST_RUN;
          end
        end
        default: begin
          state_q <= scp_pkg::ST_RUN;
        end
      endcase
    end
  end

  // A setting written during the drain is the one loaded; later writes
  // start a fresh switch once the sequencer is back in run
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      act_sel_q <= scp_pkg::SEL_RESET;
      act_src_q <= scp_pkg::SRC_WAKEUP;
      act_div_q <= scp_pkg::DIV_RESET;
      act_ok_q  <= 1'b1;
    end else if (cfg_load) begin
      act_sel_q <= i_clock_source_select;
      act_src_q <= req_src;
      act_div_q <= req_div;
      act_ok_q  <= req_ok;
    end
  end

  // ----------------------------------------------------------------
  // Output clock generation
  // ----------------------------------------------------------------
  // Counts filtered source edges, both directions, between two toggles
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      half_cnt_q <= '0;
    end else if (!act_ok_q || state_q == scp_pkg::ST_ARM) begin
      half_cnt_q <= '0;
    end else if (!cfg_load && act_div_q != '0 && src_edge) begin
      if (half_done) begin
        half_cnt_q <= '0;
      end else begin
        half_cnt_q <= half_cnt_q + 10'h001;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_q <= 1'b0;
    end else if (!act_ok_q || cfg_load) begin
      out_q <= 1'b0;
    end else if (state_q == scp_pkg::ST_ARM) begin
      out_q <= src_rise;
    end else if (act_div_q == '0) begin
      // Factor one and direct sources follow the sampled level as is
      out_q <= src_lvl;
    end else if (src_edge && half_done) begin
      // Toggling every factor half periods gives a period of factor cycles
      out_q <= ~out_q;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sys_clk <= 1'b0;
    end else begin
      o_sys_clk <= out_q;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_switch_busy <= 1'b0;
    end else begin
      o_switch_busy <= (state_q != scp_pkg::ST_RUN);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_active_select <= scp_pkg::SEL_RESET;
    end else begin
      o_active_select <= act_sel_q;
    end
  end

endmodule

// file: logic/scp_pkg.sv
// Constants shared by the system clock source and prescaler block.
// Assumes every clock pin is sampled in the 100 MHz system clock domain.
package scp_pkg;

  // ----------------------------------------------------------------
  // Clock source select encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_WAKEUP   = 2'h0;
  localparam logic [1:0] SEL_RESERVED = 2'h1;
  localparam logic [1:0] SEL_PRESCALE = 2'h2;
  localparam logic [1:0] SEL_DIRECT   = 2'h3;

  // ----------------------------------------------------------------
  // Source indices into the sampled clock vector
  // ----------------------------------------------------------------
  localparam int unsigned NUM_SRC    = 4;
  localparam logic [1:0] SRC_DIRECT  = 2'h0;
  localparam logic [1:0] SRC_CRYSTAL = 2'h1;
  localparam logic [1:0] SRC_INTERN  = 2'h2;
  localparam logic [1:0] SRC_WAKEUP  = 2'h3;

  // ----------------------------------------------------------------
  // Prescaler field and reset values
  // ----------------------------------------------------------------
  localparam int unsigned DIV_W       = 10;
  localparam int unsigned MAX_FACTOR  = 1024;
  localparam logic [9:0]  DIV_RESET   = 10'h000;
  localparam logic [1:0]  SEL_RESET   = SEL_WAKEUP;
  localparam int unsigned SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // Switch sequencer states, Gray coded along run, drain, arm
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN   = 2'h0,
    ST_DRAIN = 2'h1,
    ST_ARM   = 2'h3
  } scp_state_e;

endpackage

// file: tb/scp_clock_partner.sv
// Free-running clock sources that feed the clock source block.
// Assumes the bench picks the phase lengths in ns.
`timescale 1ns/1ps
module scp_clock_partner #(
  parameter int DIR_HI = 93,
  parameter int DIR_LO = 57,
  parameter int XTL_H  = 101,
  parameter int INT_H  = 87,
  parameter int WKU_H  = 203
) (
  output logic o_direct,
  output logic o_crystal,
  output logic o_internal,
  output logic o_wakeup
);
  initial o_crystal = 1'b0;
  initial o_internal = 1'b0;
  initial o_wakeup = 1'b0;
  initial o_direct = 1'b0;
  // Uneven duty on the direct pin, so that reshaping would show
  always begin
    #DIR_LO o_direct = 1'b1;
    #DIR_HI o_direct = 1'b0;
  end
  always #XTL_H o_crystal = ~o_crystal;
  always #INT_H o_internal = ~o_internal;
  always #WKU_H o_wakeup = ~o_wakeup;
endmodule

// file: tb/scp_clock_source_sva.sv
// Assertions on the ports of the clock source block.
// Assumes source phases last several system clock cycles.
`timescale 1ns/1ps
module scp_clock_source_sva (
  input wire logic       i_clk_sys,
  input wire logic       i_rst_b,
  input wire logic       i_direct_clock_input,
  input wire logic       i_wakeup_clock,
  input wire logic [1:0] i_clock_source_select,
  input wire logic       o_sys_clk,
  input wire logic       o_switch_busy,
  input wire logic [1:0] o_active_select
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  logic [14:0] busy_q;
  // A counter, since leaving a slow divide outlasts any delay range
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
    if (!i_rst_b) busy_q <= 15'h0000;
    else busy_q <= o_switch_busy ? busy_q + 15'h0001 : 15'h0000;
  // A switch started right after the edge may legally stretch the low phase
  a_direct_rise: assert property ((o_active_select == 2'h3 && !o_switch_busy
    && i_clock_source_select == 2'h3 && $rose(i_direct_clock_input))
    ##1 (i_clock_source_select == 2'h3) [*3] |-> ##[0:4] o_sys_clk)
    else $error("direct rise lost");
  a_direct_fall: assert property (o_active_select == 2'h3 && !o_switch_busy
    && $fell(i_direct_clock_input) |-> ##[3:7] !o_sys_clk) else $error("direct fall lost");
  a_wakeup_rise: assert property ((o_active_select == 2'h0 && !o_switch_busy
    && i_clock_source_select == 2'h0 && $rose(i_wakeup_clock))
    ##1 (i_clock_source_select == 2'h0) [*3] |-> ##[0:4] o_sys_clk)
    else $error("wakeup rise lost");
  a_min_high: assert property ($rose(o_sys_clk) |=> o_sys_clk [*3])
    else $error("short high phase");
  a_min_low: assert property ($fell(o_sys_clk) |=> !o_sys_clk [*3])
    else $error("short low phase");
  a_busy_start: assert property ($changed(i_clock_source_select) && !o_switch_busy
    |-> ##[1:3] o_switch_busy) else $error("switch not started");
  a_busy_bound: assert property (busy_q < 15'h3000) else $error("switch hangs");
  a_active_match: assert property ($fell(o_switch_busy) && $stable(i_clock_source_select)
    |-> o_active_select == i_clock_source_select) else $error("wrong active select");
  c_direct: cover property (o_active_select == 2'h3 && $rose(o_sys_clk));
  c_wakeup: cover property (o_active_select == 2'h0 && $rose(o_sys_clk));
  c_switch: cover property ($fell(o_switch_busy));
endmodule
bind scp_clock_source scp_clock_source_sva u_sva (
  .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_direct_clock_input(i_direct_clock_input),
  .i_wakeup_clock(i_wakeup_clock), .i_clock_source_select(i_clock_source_select),
  .o_sys_clk(o_sys_clk), .o_switch_busy(o_switch_busy), .o_active_select(o_active_select));

// file: tb/scp_clock_source_tb.sv
// Self-checking bench for the clock source block.
// Assumes the partner model drives all four source pins.
`timescale 1ns/1ps
module scp_clock_source_tb;
  logic       i_clk_sys = 1'b0;
  logic       i_rst_b   = 1'b0;
  logic       dir_c, xtl_c, int_c, wku_c, sys_clk, busy;
  logic [1:0] sel = 2'h0, act;
  logic       byp = 1'b1, src = 1'b0;
  logic [9:0] div = 10'h000;
  int         failures = 0, total_checks = 0, cycles = 0, hi, lo;
  always #5 i_clk_sys = ~i_clk_sys;
  scp_clock_partner PTN (.o_direct(dir_c), .o_crystal(xtl_c), .o_internal(int_c),
    .o_wakeup(wku_c));
  scp_clock_source DUT (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_direct_clock_input(dir_c), .i_crystal_input(xtl_c), .i_internal_clock(int_c),
    .i_wakeup_clock(wku_c), .i_clock_source_select(sel), .i_oscillator_bypass_select(byp),
    .i_oscillator_from_internal(src), .i_prescaler_divide_field(div),
    .o_sys_clk(sys_clk), .o_switch_busy(busy), .o_active_select(act));
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic step();
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic chk_near(input int got, input int exp, input int tol);
    total_checks++;
    if (got > exp + tol || got < exp - tol) begin
      failures++;
      $display("mismatch t=%0t count %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic chk_sel(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t active select %b", $time, got);
    end
  endtask
  task automatic set_cfg(input logic [1:0] s, input logic b, input logic n, input int f);
    step();
    sel = s;
    byp = b;
    src = n;
    div = 10'(f - 1);
    repeat (3) step();
    while (busy === 1'b1) step();
    chk_sel(act, s);
  endtask
  // Skips to the end of the first high phase so the measured phases follow a settled source
  task automatic meas();
    while (sys_clk !== 1'b1) step();
    while (sys_clk === 1'b1) step();
    lo = 0;
    hi = 0;
    while (sys_clk !== 1'b1) begin
      lo++;
      step();
    end
    while (sys_clk === 1'b1) begin
      hi++;
      step();
    end
  endtask
  task automatic s_wakeup();
    set_cfg(2'h0, 1'b1, 1'b0, 1);
    meas();
    chk_near(hi + lo, 41, 2);
  endtask
  task automatic s_direct();
    set_cfg(2'h3, 1'b1, 1'b0, 1);
    meas();
    chk_near(hi, 9, 1);
    chk_near(lo, 6, 1);
  endtask
  task automatic s_factor1();
    set_cfg(2'h2, 1'b1, 1'b0, 1);
    meas();
    chk_near(hi, 10, 1);
    set_cfg(2'h2, 1'b1, 1'b1, 1);
    meas();
    chk_near(hi, 9, 1);
  endtask
  task automatic s_divide();
    int f[3] = '{2, 3, 1024};
    for (int k = 0; k < 3; k++) begin
      set_cfg(2'h2, 1'b1, 1'b0, f[k]);
      meas();
      chk_near(hi + lo, (f[k] * 202 + 5) / 10, 2);
    end
  endtask
  // Select 01 and the unbuilt multiplier path must both idle low
  task automatic s_unbuilt();
    for (int k = 1; k <= 2; k++) begin
      set_cfg(2'(k), 1'b0, 1'b0, 1);
      hi = 0;
      repeat (100) begin
        step();
        if (sys_clk !== 1'b0) hi++;
      end
      chk_near(hi, 0, 0);
    end
  endtask
  initial begin
    repeat (5) @(posedge i_clk_sys);
    #1;
    i_rst_b = 1'b1;
    s_wakeup();
    s_direct();
    s_factor1();
    s_divide();
    s_unbuilt();
    give_verdict();
  end
endmodule
